/* File: verilog/supply_cfg.svh */
`ifndef SUPPLY_CONFIG_CFG_SVH
`define SUPPLY_CONFIG_CFG_SVH

// Serial target address and the reserved general call address
`define TARGET_ADDR        7'h2e
`define GENERAL_CALL_ADDR  7'h00

// Bits in a byte on the serial bus, bit counter width
`define BYTE_BITS          4'h8
`define BIT_CNT_W          4

// Wiper code width and reset code (lowest usable code)
`define WIPER_W            7
`define WIPER_RESET        7'h20

// Clock period and fault timer
`define CLK_PERIOD_NS      8
`define FAULT_TIME_US      10000
`define FAULT_CNT_W        21

// Pin sampling chain and pin positions in the sampled vector
`define SYNC_STAGES        3
`define PIN_COUNT          8
`define PIN_SCL            0
`define PIN_SDA            1
`define PIN_ENABLE         2
`define PIN_CUR_LIMIT      3
`define PIN_OV12           4
`define PIN_OV14           5
`define PIN_OV16           6
`define PIN_UV4            7
// Pin levels assumed in reset: bus and selects high, enable and limit low
`define PIN_IDLE_LVL       8'hf3

`endif

/* File: verilog/supply_pkg.sv */
package supply_pkg;

    typedef enum logic [7:0] {
        ST_IDLE      = 8'h01,
        ST_ADDR      = 8'h02,
        ST_ADDR_ACK  = 8'h04,
        ST_WRITE     = 8'h08,
        ST_WRITE_ACK = 8'h10,
        ST_READ      = 8'h20,
        ST_READ_ACK  = 8'h40,
        ST_IGNORE    = 8'h80
    } bus_state_t;

    typedef enum logic [3:0] {
        OV_DEFAULT = 4'h1,
        OV_12V     = 4'h2,
        OV_14V     = 4'h4,
        OV_16V     = 4'h8
    } ov_limit_t;

    typedef enum logic [1:0] {
        UV_4V = 2'h1,
        UV_7V = 2'h2
    } uv_limit_t;

    typedef struct packed {
        ov_limit_t overvoltage_limit;
        uv_limit_t undervoltage_limit;
    } limits_t;

    typedef struct packed {
        logic [2:0] ov_switch_on;
        logic       uv_switch_on;
    } switches_t;

endpackage : supply_pkg

/* File: verilog/supply_config_interface.sv */
`timescale 1ns/1ps
`include "supply_cfg.svh"
// Summary of operation
// - The three overvoltage select lines all high give the default limit, one low gives 12, 14 or 16 V.
// - The fourth select line high gives the 4 V undervoltage limit and low gives 7 V.
// - Each limit switch conducts while its select line is low and is open while it is high.
// - The general call address is ignored and never acknowledged.
// - A matching address is acknowledged by holding data low during the acknowledge clock high.
// - The target answers at seven-bit address 0x2E for writes and reads.
// - The data byte after the address sets the wiper position.
// - If the current stays at its limit until the fault timer expires, the switch opens and fault asserts.
module supply_config_interface #(
    parameter int unsigned FAULT_CYCLES = (`FAULT_TIME_US * 1000) / `CLK_PERIOD_NS
) (
    input  wire logic                clk_i,            // 125 MHz clock
    input  wire logic                rst_n_i,          // Async reset, active low
    input  wire logic                scl_i,            // Serial clock from host
    input  wire logic                sda_i,            // Serial data line level
    output logic                     sda_o,            // Serial data drive value
    output logic                     sda_oe_n_o,       // Low while pulling data low
    input  wire logic                enable_i,         // Supply enable from host
    input  wire logic                current_limit_i,  // Output current at limit
    input  wire logic                ov_select_12v_n_i, // Overvoltage select 12 V, low
    input  wire logic                ov_select_14v_n_i, // Overvoltage select 14 V, low
    input  wire logic                ov_select_16v_n_i, // Overvoltage select 16 V, low
    input  wire logic                uv_select_4v_i,   // High 4 V, low 7 V
    output logic [`WIPER_W-1:0]      wiper_code_o,     // Wiper position
    output supply_pkg::limits_t      limits_o,         // Decoded protection limits
    output supply_pkg::switches_t    switches_o,       // Limit switch conduct states
    output logic                     output_on_o,      // Protection switch closed
    output logic                     fault_o,          // Latched fault
    output logic                     power_good_flag_o // Output on without fault
);

    // Pin sampling: three stages, a change counts once stages two and three agree
    localparam logic [`PIN_COUNT-1:0] PIN_IDLE = `PIN_IDLE_LVL;
    logic [`PIN_COUNT-1:0] pins;
    logic [`PIN_COUNT-1:0] pin_lvl;
    assign pins = {uv_select_4v_i, ov_select_16v_n_i, ov_select_14v_n_i, ov_select_12v_n_i,
                   current_limit_i, enable_i, sda_i, scl_i};
    genvar gi;
    generate
        for (gi = 0; gi < `PIN_COUNT; gi++)
        begin : g_sync
            logic [`SYNC_STAGES-1:0] sync_q;
            logic [`SYNC_STAGES-1:0] sync_d;
            logic                    lvl_q;
            logic                    lvl_d;
            always_comb
            begin
                sync_d = {sync_q[`SYNC_STAGES-2:0], pins[gi]};
                lvl_d  = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
            end
            always_ff @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    sync_q <= {`SYNC_STAGES{PIN_IDLE[gi]}};
                    lvl_q  <= PIN_IDLE[gi];
                end
                else
                begin
                    sync_q <= sync_d;
                    lvl_q  <= lvl_d;
                end
            end
            assign pin_lvl[gi] = lvl_q;
        end
    endgenerate
    // Serial target
    supply_pkg::bus_state_t  st_q, st_d;
    logic                    scl_q, scl_d;
    logic                    sda_q, sda_d;
    logic [`BIT_CNT_W-1:0]   cnt_q, cnt_d;
    logic [7:0]              rx_q, rx_d;
    logic [7:0]              tx_q, tx_d;
    logic                    drv_q, drv_d;
    logic                    nack_q, nack_d;
    logic [`WIPER_W-1:0]     wiper_q, wiper_d;
    logic                    scl_rise, scl_fall, start_seen, stop_seen;
    always_comb
    begin
        scl_d      = pin_lvl[`PIN_SCL];
        sda_d      = pin_lvl[`PIN_SDA];
        scl_rise   = scl_d & ~scl_q;
        scl_fall   = ~scl_d & scl_q;
        start_seen = scl_d & scl_q & sda_q & ~sda_d;
        stop_seen  = scl_d & scl_q & ~sda_q & sda_d;
        st_d       = st_q;
        cnt_d      = cnt_q;
        rx_d       = rx_q;
        tx_d       = tx_q;
        drv_d      = drv_q;
        nack_d     = nack_q;
        wiper_d    = wiper_q;
        if (start_seen)
        begin
            st_d  = supply_pkg::ST_ADDR;
            cnt_d = '0;
            drv_d = 1'b0;
        end
        else if (stop_seen)
        begin
            st_d  = supply_pkg::ST_IDLE;
            drv_d = 1'b0;
        end
        else if (scl_rise)
        begin
            case (st_q)
                supply_pkg::ST_ADDR, supply_pkg::ST_WRITE:
                begin
                    rx_d  = {rx_q[6:0], sda_d};
                    cnt_d = cnt_q + 1'b1;
                end
                supply_pkg::ST_READ:     cnt_d = cnt_q + 1'b1;
                supply_pkg::ST_READ_ACK: nack_d = sda_d;
                default:                 cnt_d = cnt_q;
            endcase
        end
        else if (scl_fall)
        begin
            case (st_q)
                supply_pkg::ST_ADDR:
                    if (cnt_q == `BYTE_BITS)
                    begin
                        if (rx_q[7:1] == `TARGET_ADDR && rx_q[7:1] != `GENERAL_CALL_ADDR)
                        begin
                            st_d  = supply_pkg::ST_ADDR_ACK;
                            drv_d = 1'b1;
                        end
                        else
                            st_d = supply_pkg::ST_IGNORE;
                    end
                supply_pkg::ST_ADDR_ACK:
                begin
                    cnt_d = '0;
                    if (rx_q[0])
                    begin
                        st_d  = supply_pkg::ST_READ;
                        tx_d  = {1'b0, wiper_q};
                        drv_d = 1'b1;
                    end
                    else
                    begin
                        st_d  = supply_pkg::ST_WRITE;
                        drv_d = 1'b0;
                    end
                end
                supply_pkg::ST_WRITE:
                    if (cnt_q == `BYTE_BITS)
                    begin
                        wiper_d = rx_q[`WIPER_W-1:0];
                        st_d    = supply_pkg::ST_WRITE_ACK;
                        drv_d   = 1'b1;
                    end
                supply_pkg::ST_WRITE_ACK:
                begin
                    st_d  = supply_pkg::ST_WRITE;
                    cnt_d = '0;
                    drv_d = 1'b0;
                end
                supply_pkg::ST_READ:
                    if (cnt_q == `BYTE_BITS)
                    begin
                        st_d  = supply_pkg::ST_READ_ACK;
                        drv_d = 1'b0;
                    end
                    else
                    begin
                        tx_d  = {tx_q[6:0], 1'b0};
                        drv_d = ~tx_q[6];
                    end
                supply_pkg::ST_READ_ACK:
                    if (!nack_q)
                    begin
                        st_d  = supply_pkg::ST_READ;
                        cnt_d = '0;
                        tx_d  = {1'b0, wiper_q};
                        drv_d = 1'b1;                          // Top bit of a read is zero
                    end
                    else
                        st_d = supply_pkg::ST_IGNORE;
                default: st_d = st_q;
            endcase
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q    <= supply_pkg::ST_IDLE;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            cnt_q   <= '0;
            rx_q    <= '0;
            tx_q    <= '0;
            drv_q   <= 1'b0;
            nack_q  <= 1'b1;
            wiper_q <= `WIPER_RESET;
        end
        else
        begin
            st_q    <= st_d;
            scl_q   <= scl_d;
            sda_q   <= sda_d;
            cnt_q   <= cnt_d;
            rx_q    <= rx_d;
            tx_q    <= tx_d;
            drv_q   <= drv_d;
            nack_q  <= nack_d;
            wiper_q <= wiper_d;
        end
    end
    assign sda_o        = 1'b0;
    assign sda_oe_n_o   = ~drv_q;
    assign wiper_code_o = wiper_q;
    // Limit decode and switch states
    supply_pkg::limits_t   lim_q, lim_d;
    supply_pkg::switches_t sw_q, sw_d;
    always_comb
    begin
        sw_d.ov_switch_on = ~pin_lvl[`PIN_OV16:`PIN_OV12];
        sw_d.uv_switch_on = ~pin_lvl[`PIN_UV4];
        lim_d.undervoltage_limit = pin_lvl[`PIN_UV4] ? supply_pkg::UV_4V
                                                     : supply_pkg::UV_7V;
        case (pin_lvl[`PIN_OV16:`PIN_OV12])
            3'h6:    lim_d.overvoltage_limit = supply_pkg::OV_12V;
            3'h5:    lim_d.overvoltage_limit = supply_pkg::OV_14V;
            3'h3:    lim_d.overvoltage_limit = supply_pkg::OV_16V;
            default: lim_d.overvoltage_limit = supply_pkg::OV_DEFAULT;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lim_q <= '{supply_pkg::OV_DEFAULT, supply_pkg::UV_4V};
            sw_q  <= '0;
        end
        else
        begin
            lim_q <= lim_d;
            sw_q  <= sw_d;
        end
    end
    assign limits_o   = lim_q;
    assign switches_o = sw_q;
    // Fault timer, cleared when enable or the current limit drops, and latch, cleared only by dropping enable
    logic [`FAULT_CNT_W-1:0] ft_q, ft_d;
    logic                    fault_q, fault_d;
    always_comb
    begin
        ft_d    = ft_q;
        fault_d = fault_q;
        if (!pin_lvl[`PIN_ENABLE])
        begin
            ft_d    = '0;
            fault_d = 1'b0;
        end
        else if (!fault_q && pin_lvl[`PIN_CUR_LIMIT])
        begin
            if (ft_q == `FAULT_CNT_W'(FAULT_CYCLES - 1))
                fault_d = 1'b1;
            else
                ft_d = ft_q + 1'b1;
        end
        else
        begin
            ft_d = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ft_q    <= '0;
            fault_q <= 1'b0;
        end
        else
        begin
            ft_q    <= ft_d;
            fault_q <= fault_d;
        end
    end
    assign fault_o           = fault_q;
    assign output_on_o       = pin_lvl[`PIN_ENABLE] & ~fault_q;
    assign power_good_flag_o = output_on_o;
endmodule : supply_config_interface

/* File: verif/supply_config_chk.sv */
`timescale 1ns/1ps
module supply_config_chk #(
    parameter int unsigned FAULT_CYCLES = 20
) (
    input wire logic                  clk_i,             // Clock
    input wire logic                  rst_n_i,           // Reset
    input wire logic                  scl_i,             // Bus clock
    input wire logic                  sda_i,             // Bus data
    input wire logic                  sda_o,             // Data value
    input wire logic                  sda_oe_n_o,        // Data pull
    input wire logic                  enable_i,          // Enable
    input wire logic                  current_limit_i,   // At limit
    input wire logic                  ov_select_12v_n_i, // Select
    input wire logic                  ov_select_14v_n_i, // Select
    input wire logic                  ov_select_16v_n_i, // Select
    input wire logic                  uv_select_4v_i,    // Select
    input wire logic [6:0]            wiper_code_o,      // Wiper
    input wire supply_pkg::limits_t   limits_o,          // Limits
    input wire supply_pkg::switches_t switches_o,        // Switches
    input wire logic                  output_on_o,       // On
    input wire logic                  fault_o,           // Fault
    input wire logic                  power_good_flag_o  // Good
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire  [3:0]  sel = {uv_select_4v_i, ov_select_16v_n_i, ov_select_14v_n_i, ov_select_12v_n_i};
    logic [31:0] lim_d, lim_q, enlo_d, enlo_q;
    logic [3:0]  ov_exp;
    always_comb
    begin
        lim_d  = (enable_i && current_limit_i) ? lim_q + 32'h1 : 32'h0;
        enlo_d = enable_i ? 32'h0 : enlo_q + 32'h1;
        case (sel[2:0])
            3'h6:    ov_exp = 4'h2;
            3'h5:    ov_exp = 4'h4;
            3'h3:    ov_exp = 4'h8;
            default: ov_exp = 4'h1;
        endcase
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lim_q  <= 32'h0;
            enlo_q <= 32'h0;
        end
        else
        begin
            lim_q  <= lim_d;
            enlo_q <= enlo_d;
        end
    end
    a_ov_limit: assert property (
        $stable(sel)[*8] |-> limits_o.overvoltage_limit == ov_exp)
        else $error("overvoltage limit wrong");
    a_uv_limit: assert property (
        $stable(sel)[*8] |-> limits_o.undervoltage_limit == (sel[3] ? 2'h1 : 2'h2))
        else $error("undervoltage limit wrong");
    a_switch_state: assert property (
        $stable(sel)[*8] |-> switches_o == {~sel[2:0], ~sel[3]})
        else $error("switch state wrong");
    a_ack_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
        else $error("data drive changed while clock high");
    a_sda_value: assert property (sda_o == 1'b0)
        else $error("data drive value not low");
    a_wiper_update: assert property ($changed(wiper_code_o) |-> !scl_i)
        else $error("wiper changed while clock high");
    a_fault_cause: assert property ($rose(fault_o) |-> lim_q >= FAULT_CYCLES)
        else $error("fault before timer expiry");
    a_fault_timely: assert property (lim_q == FAULT_CYCLES + 10 |-> fault_o)
        else $error("fault missing after timer expiry");
    a_fault_off: assert property (fault_o |-> !output_on_o && !power_good_flag_o)
        else $error("output on during fault");
    a_fault_held: assert property (fault_o && enable_i |=> fault_o)
        else $error("fault cleared while enabled");
    a_fault_clear: assert property ($fell(fault_o) |-> enlo_q >= 2)
        else $error("fault cleared without enable low");
endmodule : supply_config_chk
bind supply_config_interface supply_config_chk #(.FAULT_CYCLES(FAULT_CYCLES)) i_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .enable_i(enable_i), .current_limit_i(current_limit_i),
    .ov_select_12v_n_i(ov_select_12v_n_i), .ov_select_14v_n_i(ov_select_14v_n_i),
    .ov_select_16v_n_i(ov_select_16v_n_i), .uv_select_4v_i(uv_select_4v_i),
    .wiper_code_o(wiper_code_o), .limits_o(limits_o), .switches_o(switches_o),
    .output_on_o(output_on_o), .fault_o(fault_o), .power_good_flag_o(power_good_flag_o));

/* File: verif/i2c_host_model.sv */
`timescale 1ns/1ps
module i2c_host_model (
    input  wire logic clk_i, // Clock
    input  wire logic sda_i, // Resolved data line
    output logic      scl_o, // Bus clock
    output logic      sda_o  // Data drive, high releases
);
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic half();
        repeat (8) @(posedge clk_i);
    endtask : half
    task automatic start_c();
        @(posedge clk_i);
        sda_o <= 1'b0;
        half();
        scl_o <= 1'b0;
    endtask : start_c
    task automatic bit_x(input logic b, output logic r);
        @(posedge clk_i);
        sda_o <= b;
        half();
        scl_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        r = sda_i;
        repeat (4) @(posedge clk_i);
        scl_o <= 1'b0;
    endtask : bit_x
    task automatic stop_c();
        @(posedge clk_i);
        sda_o <= 1'b0;
        half();
        scl_o <= 1'b1;
        half();
        sda_o <= 1'b1;
        half();
    endtask : stop_c
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask : send
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(last, r);
    endtask : recv
endmodule : i2c_host_model

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
    localparam int unsigned FC = 20;
    logic                  clk_i = 1'b0;
    logic                  rst_n_i = 1'b0;
    logic                  en = 1'b0;
    logic                  lim = 1'b0;
    logic [3:0]            sel = 4'hf;
    logic                  scl, hsda, sda_o, sda_oe_n, on_o, pg, fault, aa, da;
    logic [6:0]            wiper;
    logic [7:0]            rd;
    supply_pkg::limits_t   lims;
    supply_pkg::switches_t sws;
    int                    n_mismatch = 0;
    int                    checks_done = 0;
    wire                   sda_line = hsda & (sda_oe_n | sda_o);
    always #4 clk_i = ~clk_i;
    i2c_host_model i_host (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_o(hsda));
    supply_config_interface #(.FAULT_CYCLES(FC)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n), .enable_i(en), .current_limit_i(lim),
        .ov_select_12v_n_i(sel[0]), .ov_select_14v_n_i(sel[1]), .ov_select_16v_n_i(sel[2]),
        .uv_select_4v_i(sel[3]), .wiper_code_o(wiper), .limits_o(lims), .switches_o(sws),
        .output_on_o(on_o), .fault_o(fault), .power_good_flag_o(pg));
    task automatic test_done();
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.start_c();
        i_host.send(a, aa);
        i_host.send(d, da);
        i_host.stop_c();
    endtask : wr
    task automatic t_write();
        logic [7:0] codes [3] = '{8'h20, 8'h7f, 8'h5c};
        foreach (codes[i])
        begin
            wr({7'h2e, 1'b0}, codes[i]);
            chk({7'h00, aa}, 8'h01);
            chk({7'h00, da}, 8'h01);
            chk({1'h0, wiper}, codes[i]);
        end
    endtask : t_write
    task automatic t_refuse();
        logic [6:0] adrs [2] = '{7'h00, 7'h2f};
        foreach (adrs[i])
        begin
            wr({adrs[i], 1'b0}, 8'h33);
            chk({7'h00, aa}, 8'h00);
            chk({1'h0, wiper}, 8'h5c);
        end
    endtask : t_refuse
    task automatic t_read();
        i_host.start_c();
        i_host.send({7'h2e, 1'b1}, aa);
        i_host.recv(1'b1, rd);
        i_host.stop_c();
        chk({7'h00, aa}, 8'h01);
        chk(rd, 8'h5c);
    endtask : t_read
    task automatic t_limits();
        logic [3:0] pats [5] = '{4'hf, 4'he, 4'hd, 4'hb, 4'h7};
        logic [3:0] ovx [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1};
        foreach (pats[i])
        begin
            @(posedge clk_i);
            sel <= pats[i];
            repeat (8) @(posedge clk_i);
            chk({2'h0, lims}, {2'h0, ovx[i], pats[i][3] ? 2'h1 : 2'h2});
            chk({4'h0, sws}, {4'h0, ~pats[i][2:0], ~pats[i][3]});
        end
    endtask : t_limits
    task automatic t_fault();
        int k;
        @(posedge clk_i);
        en <= 1'b1;
        lim <= 1'b1;
        repeat (FC / 2) @(posedge clk_i);
        chk({6'h00, on_o, pg}, 8'h03);
        lim <= 1'b0;
        // Long enough for the pin filter to see the drop, so the timer restarts
        repeat (8) @(posedge clk_i);
        lim <= 1'b1;
        for (k = 0; k < FC + 20 && fault !== 1'b1; k++) @(posedge clk_i);
        if (k >= FC + 20)
        begin
            n_mismatch++;
            test_done();
        end
        else
        begin
            chk({7'h00, k >= FC}, 8'h01);
            chk({7'h00, k <= FC + 8}, 8'h01);
            chk({6'h00, on_o, pg}, 8'h00);
            lim <= 1'b0;
            repeat (10) @(posedge clk_i);
            chk({7'h00, fault}, 8'h01);
            en <= 1'b0;
            repeat (8) @(posedge clk_i);
            chk({7'h00, fault}, 8'h00);
            en <= 1'b1;
            repeat (8) @(posedge clk_i);
            chk({7'h00, on_o}, 8'h01);
        end
    endtask : t_fault
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk({wiper, sda_oe_n}, 8'h41);
        t_write();
        t_refuse();
        t_read();
        t_limits();
        t_fault();
        test_done();
    end
endmodule : testbench
